// ===== osf_regs.svh
`ifndef OSF_REGS_SVH
`define OSF_REGS_SVH
// Register byte offsets
`define OSF_CTRL_OFF 12'h000
`define OSF_STATE_OFF 12'h004
`define OSF_APP_OFF 12'h008
`define OSF_FBVAL_OFF 12'h00C
`define OSF_SPECIAL_OFF 12'h010
`define OSF_ALARM_OFF 12'h014
`define OSF_FEN_OFF 12'h018
`define OSF_FVAL_OFF 12'h01C
`define OSF_STATUS_OFF 12'h020
`define OSF_CLUSTER_OFF 12'h024
`define OSF_IMAGE_OFF 12'h028
`define OSF_CMD_OFF 12'h02C
// CTRL fields
`define OSF_CTRL_HOLD 0
`define OSF_CTRL_REARM 1
`define OSF_CTRL_ALARM_EN 2
// CMD fields (write pulses)
`define OSF_CMD_COLD 0
`define OSF_CMD_WARM 1
`define OSF_CMD_DOWNLOAD 2
// Rearm period
`define OSF_REARM_MS 1000
`define OSF_CLK_MHZ 100
`define OSF_REARM_CYC (`OSF_REARM_MS * 1000 * `OSF_CLK_MHZ)
`endif

// ===== osf_pkg.sv
package osf_pkg;
   typedef enum logic [2:0] {
      OSF_BOOTING,
      OSF_EMPTY,
      OSF_POWERLESS,
      OSF_STOPPED,
      OSF_HALTED,
      OSF_RUNNING
   } osf_ctl_state_e;
   typedef struct packed {
      logic [15:0] hold_app;
      logic [15:0] fb_val;
      logic [15:0] special;
      logic [15:0] fen;
      logic [15:0] fval;
      logic [15:0] image;
      logic [15:0] pins;
      logic [3:0] grp_trip;
      logic [3:0] cluster;
      logic err_flag;
      logic hold;
      logic rearm_en;
      logic alarm_en;
      logic [3:0] alarm_idx;
      logic [2:0] state;
      logic was_run;
      logic [31:0] rearm_cnt;
      logic [31:0] prdata;
   } osf_st_s;
endpackage

// ===== osf_output_state_fallback_control.sv
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "osf_regs.svh"
// Overview of operation
// - In running state each output follows the application value.
// - Boot, powerless: source low, sink high, relay open.
// - After download, warm or cold start outputs follow fallback strategy.
// - Leaving running to stopped or halted applies and keeps fallback values.
// - Hold clear gives configured fallback; hold set keeps last value.
// - Pulse and reflex outputs go inactive (source low, sink high) when holding is selected.
// - Alarm output never falls back; in stopped and halted it keeps the application value.
// - All outputs but the alarm and held sink-type counter or pulse outputs zero after download; unforced outputs zero in empty state.
// - Output image always mirrors the values driven on the pins.
// - Counter or pulse outputs go inactive in fallback with hold set: source low, sink high.
// - Forced outputs take their forced value over every other source except a group trip.
// - Cold start or download releases all forcing.
// - Forcing survives online changes and programming tool disconnection.
// - Forcing ignored on outputs owned by counter or pulse functions.
// - Group fault drives group to zero; rearm retries once per second.
// - Sink type outputs are never rearmed automatically.
// - Only a true output shorted to zero volts is flagged.
// - Faults set the error flag and record the cluster word.
// - Rearm only when rearm enable bit is one; resets to zero.
module osf_output_state_fallback_control
   import osf_pkg::*;
#(
   parameter int NOUT = 16,
   parameter int NGRP = 4,
   parameter logic [15:0] SINK_MASK = 16'h0000,
   parameter logic [15:0] RELAY_MASK = 16'h0000,
   parameter int REARM_CYC = `OSF_REARM_CYC
) (
   input wire logic pclk, // Bus clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic [NOUT-1:0] short_in, // Per-output short sense, async
   input wire logic [NOUT-1:0] app_val, // Application output values
   output logic [NOUT-1:0] out_drive // Logical output drive
);
   localparam int GW = NOUT / NGRP;

   osf_st_s q, d;
   logic [NOUT-1:0] sh1, sh2, sh3, sh_ok;
   logic wr, rd;
   logic [NOUT-1:0] init_v, fb_eff, base, forced, grp_mask, alarm_bit, sh_trip;
   logic [NOUT-1:0] app_eff;
   logic [NGRP-1:0] grp_fault;
   logic cold, warm, dl;

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = q.prdata;
   assign out_drive = q.pins;
   assign cold = wr && paddr == `OSF_CMD_OFF && pwdata[`OSF_CMD_COLD];
   assign warm = wr && paddr == `OSF_CMD_OFF && pwdata[`OSF_CMD_WARM];
   assign dl = wr && paddr == `OSF_CMD_OFF && pwdata[`OSF_CMD_DOWNLOAD];

   // Short sense synchroniser, three stages
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh1 <= '0;
         sh2 <= '0;
         sh3 <= '0;
         sh_ok <= '0;
      end else begin
         sh1 <= short_in;
         sh2 <= sh1;
         sh3 <= sh2;
         for (int i = 0; i < NOUT; i++) begin
            if (sh2[i] == sh3[i]) begin
               sh_ok[i] <= sh3[i];
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NGRP; g++) begin : grp
         assign grp_fault[g] = |(sh_ok[g*GW +: GW] & q.pins[g*GW +: GW] & ~SINK_MASK[g*GW +: GW]);
         assign grp_mask[g*GW +: GW] = {GW{q.grp_trip[g]}};
      end
   endgenerate

   always_comb begin
      alarm_bit = '0;
      if (q.alarm_en) begin
         alarm_bit[q.alarm_idx] = 1'b1;
      end
   end

   assign init_v = SINK_MASK & ~RELAY_MASK;

   always_comb begin
      for (int i = 0; i < NOUT; i++) begin
         if (q.special[i]) begin
            fb_eff[i] = q.hold ? SINK_MASK[i] : q.fb_val[i];
         end else begin
            fb_eff[i] = q.hold ? q.hold_app[i] : q.fb_val[i];
         end
      end
      fb_eff = fb_eff & ~alarm_bit;
   end

   assign app_eff = app_val;

   always_comb begin
      unique case (osf_ctl_state_e'(q.state))
         OSF_RUNNING: base = app_eff;
         OSF_EMPTY: base = '0;
         OSF_BOOTING, OSF_POWERLESS: base = init_v;
         OSF_STOPPED, OSF_HALTED: base = (fb_eff & ~alarm_bit) | (app_eff & alarm_bit);
         default: base = init_v;
      endcase
   end

   assign forced = (base & ~(q.fen & ~q.special)) | (q.fval & q.fen & ~q.special);
   assign sh_trip = forced & ~grp_mask;

   always_comb begin
      d = q;
      d.prdata = '0;
      d.pins = sh_trip;
      d.image = sh_trip;
      if (q.state == OSF_RUNNING) begin
         d.hold_app = app_eff;
      end
      if (wr) begin
         unique case (paddr)
            `OSF_CTRL_OFF: begin
               d.hold = pwdata[`OSF_CTRL_HOLD];
               d.rearm_en = pwdata[`OSF_CTRL_REARM];
               d.alarm_en = pwdata[`OSF_CTRL_ALARM_EN];
            end
            `OSF_STATE_OFF: d.state = pwdata[2:0];
            `OSF_FBVAL_OFF: d.fb_val = pwdata[15:0];
            `OSF_SPECIAL_OFF: d.special = pwdata[15:0];
            `OSF_ALARM_OFF: d.alarm_idx = pwdata[3:0];
            `OSF_FEN_OFF: d.fen = pwdata[15:0];
            `OSF_FVAL_OFF: d.fval = pwdata[15:0];
            `OSF_STATUS_OFF: d.err_flag = 1'b0;
            `OSF_CLUSTER_OFF: d.cluster = '0;
            default: ;
         endcase
      end
      if (rd) begin
         unique case (paddr)
            `OSF_CTRL_OFF: d.prdata = {29'h0, q.alarm_en, q.rearm_en, q.hold};
            `OSF_STATE_OFF: d.prdata = {29'h0, q.state};
            `OSF_APP_OFF: d.prdata = {16'h0, app_eff};
            `OSF_FBVAL_OFF: d.prdata = {16'h0, q.fb_val};
            `OSF_SPECIAL_OFF: d.prdata = {16'h0, q.special};
            `OSF_ALARM_OFF: d.prdata = {28'h0, q.alarm_idx};
            `OSF_FEN_OFF: d.prdata = {16'h0, q.fen};
            `OSF_FVAL_OFF: d.prdata = {16'h0, q.fval};
            `OSF_STATUS_OFF: d.prdata = {31'h0, q.err_flag};
            `OSF_CLUSTER_OFF: d.prdata = {28'h0, q.cluster};
            `OSF_IMAGE_OFF: d.prdata = {16'h0, q.image};
            default: d.prdata = '0;
         endcase
      end
      if (cold || warm || dl) begin
         d.state = OSF_STOPPED;
         d.hold_app = '0;
      end
      if (dl) begin
         d.fb_val = '0;
      end
      if (cold || dl) begin
         d.fen = '0;
         d.fval = '0;
         d.rearm_en = 1'b0;
      end
      if (q.rearm_cnt >= 32'(REARM_CYC - 1)) begin
         d.rearm_cnt = '0;
         if (q.rearm_en) begin
            for (int k = 0; k < NGRP; k++) begin
               if (!(|SINK_MASK[k*GW +: GW])) begin
                  d.grp_trip[k] = 1'b0;
               end
            end
         end
      end else begin
         d.rearm_cnt = q.rearm_cnt + 32'h0000_0001;
      end
      for (int k = 0; k < NGRP; k++) begin
         if (grp_fault[k]) begin
            d.grp_trip[k] = 1'b1;
            d.cluster[k] = 1'b1;
            d.err_flag = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// ===== osf_output_state_fallback_control_asserts.sv
`timescale 1ns/10ps
module osf_ofc_asserts
   import osf_pkg::*;
#(
   parameter int NOUT = 16
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Direction
   input wire logic [11:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic [NOUT-1:0] short_in, // Short sense
   input wire logic [NOUT-1:0] app_val, // App values
   input wire logic [NOUT-1:0] out_drive // Drive
);
   logic [2:0] st_q;
   logic [15:0] fen_q, fval_q, spc_q;
   logic [1:0] calm_q;
   logic trip_q;
   logic wr;
   assign wr = psel && penable && pwrite;
   // Shadow copies; checks wait three quiet cycles for the output lag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= 3'h0;
         fen_q <= 16'h0000;
         fval_q <= 16'h0000;
         spc_q <= 16'h0000;
         calm_q <= 2'h0;
         trip_q <= 1'b0;
      end else begin
         calm_q <= wr ? 2'h0 : (calm_q == 2'h3 ? calm_q : calm_q + 2'h1);
         trip_q <= trip_q | (|short_in);
         if (wr && paddr == 12'h004) st_q <= pwdata[2:0];
         // Restart commands put the controller in stopped state
         if (wr && paddr == 12'h02C && (|pwdata[2:0])) st_q <= OSF_STOPPED;
         if (wr && paddr == 12'h010) spc_q <= pwdata[15:0];
         if (wr && paddr == 12'h01C) fval_q <= pwdata[15:0];
         if (wr && paddr == 12'h018) fen_q <= pwdata[15:0];
         if (wr && paddr == 12'h02C && (pwdata[0] || pwdata[2])) fen_q <= 16'h0000;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_run;
      calm_q == 2'h3 && !trip_q && fen_q == 16'h0000 && st_q == OSF_RUNNING && $stable(app_val)
         && app_val == $past(app_val, 2) |-> out_drive == app_val;
   endproperty
   a_run: assert property (p_run) else $error("drive differs from app value");
   property p_empty;
      calm_q == 2'h3 && fen_q == 16'h0000 && st_q == OSF_EMPTY |-> out_drive == '0;
   endproperty
   a_empty: assert property (p_empty) else $error("empty state drive not zero");
   property p_boot;
      calm_q == 2'h3 && fen_q == 16'h0000 && (st_q == OSF_BOOTING || st_q == OSF_POWERLESS) |-> out_drive == '0;
   endproperty
   a_boot: assert property (p_boot) else $error("init state drive wrong");
   property p_force;
      calm_q == 2'h3 && !trip_q |-> (out_drive & fen_q & ~spc_q) == (fval_q & fen_q & ~spc_q);
   endproperty
   a_force: assert property (p_force) else $error("forced bit not at forced value");
   property p_trip;
      $rose(short_in[0]) && out_drive[0] |-> ##[1:8] out_drive[3:0] == 4'h0;
   endproperty
   a_trip: assert property (p_trip) else $error("group not cut on short");
   property p_rdy;
      psel && penable |-> pready;
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready low in access");
   property p_err;
      psel |-> !pslverr;
   endproperty
   a_err: assert property (p_err) else $error("bus error raised");
   property p_rdz;
      !(psel && penable) |-> prdata == 32'h0000_0000;
   endproperty
   a_rdz: assert property (p_rdz) else $error("read data outside access");
endmodule
bind osf_output_state_fallback_control osf_ofc_asserts #(.NOUT(NOUT)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .short_in(short_in), .app_val(app_val), .out_drive(out_drive));

// ===== osf_actuator_model.sv
`timescale 1ns/10ps
module osf_actuator_model (
   input wire logic [15:0] out_drive, // Drive
   input wire logic [15:0] fault_mask, // Loads shorted to 0 V
   output logic [15:0] short_in // Overcurrent sense
);
   assign short_in = fault_mask & out_drive;
endmodule

// ===== test_output_state_fallback_control.sv
`timescale 1ns/10ps
module test_output_state_fallback_control
   import osf_pkg::*;
;
   typedef struct packed {
      logic [2:0] ctrl;
      logic [15:0] spc;
      osf_ctl_state_e st;
      logic [15:0] app;
      logic [15:0] exp;
   } osf_row_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] app_val, out_drive, short_in, fault_mask;
   int mismatches, checks;
   osf_row_s rows [11] = '{
      '{3'h0, 16'h0000, OSF_RUNNING, 16'hA5C3, 16'hA5C3},
      '{3'h0, 16'h0000, OSF_STOPPED, 16'h1234, 16'h0F0F},
      '{3'h0, 16'h0000, OSF_RUNNING, 16'h1234, 16'h1234},
      '{3'h1, 16'h0000, OSF_HALTED, 16'hFFFF, 16'h1234},
      '{3'h0, 16'h0000, OSF_EMPTY, 16'hFFFF, 16'h0000},
      '{3'h0, 16'h0000, OSF_BOOTING, 16'hFFFF, 16'h0000},
      '{3'h0, 16'h0000, OSF_POWERLESS, 16'hFFFF, 16'h0000},
      '{3'h1, 16'h0003, OSF_RUNNING, 16'hFFFF, 16'hFFFF},
      '{3'h1, 16'h0003, OSF_STOPPED, 16'h0000, 16'hFFFC},
      '{3'h4, 16'h0000, OSF_RUNNING, 16'h0010, 16'h0010},
      '{3'h4, 16'h0000, OSF_STOPPED, 16'h0010, 16'h0F1F}};
   osf_output_state_fallback_control #(.REARM_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .short_in(short_in), .app_val(app_val), .out_drive(out_drive));
   osf_actuator_model u_load (.out_drive(out_drive), .fault_mask(fault_mask), .short_in(short_in));
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Generous: whole run needs about 350 cycles
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      print_verdict;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, app_val, fault_mask} = '0;
      mismatches = 0;
      checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1, 12'h00C, 32'h0000_0F0F);
      apb(1, 12'h014, 32'h0000_0004);
      foreach (rows[i]) begin
         apb(1, 12'h000, {29'h0, rows[i].ctrl});
         apb(1, 12'h010, {16'h0000, rows[i].spc});
         apb(1, 12'h004, {29'h0, rows[i].st});
         app_val <= rows[i].app;
         repeat (4) @(posedge pclk);
         chk(out_drive, rows[i].exp);
         apb(0, 12'h028, 32'h0);
         chk(rd, rows[i].exp);
      end
      $display("state table done");
      presetn <= 1'b0;
      app_val <= 16'h0000;
      repeat (2) @(posedge pclk);
      chk(out_drive, 32'h0);
      presetn <= 1'b1;
      apb(0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(0, 12'h018, 32'h0);
      chk(rd, 32'h0);
      apb(0, 12'h0FC, 32'h0);
      chk(rd, 32'h0);
      $display("reset and map test done");
      apb(1, 12'h004, 32'h0000_0005);
      apb(1, 12'h010, 32'h0000_0003);
      apb(1, 12'h01C, 32'h0000_0011);
      apb(1, 12'h018, 32'h0000_0013);
      repeat (4) @(posedge pclk);
      chk(out_drive, 32'h0010);
      apb(1, 12'h02C, 32'h0000_0001);
      apb(1, 12'h004, 32'h0000_0005);
      repeat (4) @(posedge pclk);
      chk(out_drive, 32'h0);
      $display("force test done");
      app_val <= 16'hFFFF;
      repeat (4) @(posedge pclk);
      fault_mask <= 16'h0001;
      repeat (10) @(posedge pclk);
      chk(out_drive, 32'hFFF0);
      apb(0, 12'h020, 32'h0);
      chk(rd, 32'h1);
      apb(0, 12'h024, 32'h0);
      chk(rd, 32'h1);
      repeat (60) @(posedge pclk);
      chk(out_drive, 32'hFFF0);
      fault_mask <= 16'h0000;
      apb(1, 12'h000, 32'h0000_0002);
      repeat (30) @(posedge pclk);
      chk(out_drive, 32'hFFFF);
      $display("short test done");
      print_verdict;
   end
endmodule
